//--- hw/dcc_map.svh
// register offsets, field positions and reset values of the comparator control block
`ifndef DCC_MAP_SVH
`define DCC_MAP_SVH
`define DCC_ADDR_INTCTL     8'h0b
`define DCC_ADDR_PFLAGS     8'h0c
`define DCC_ADDR_CMPCTL     8'h1f
`define DCC_ADDR_PORTDIR    8'h85
`define DCC_ADDR_PENABLES   8'h8c
`define DCC_ADDR_VREFCTL    8'h9f
`define DCC_ADDR_CHGSTAT    8'h0d
`define DCC_ADDR_CHGMASK    8'h8d
`define DCC_RST_INTCTL      8'h00
`define DCC_RST_PFLAGS      8'h00
`define DCC_RST_CMPCTL      8'h00
`define DCC_RST_PORTDIR     8'h1f
`define DCC_RST_PENABLES    8'h00
`define DCC_RST_VREFCTL     8'h00
`define DCC_BIT_GLOBAL_EN   7
`define DCC_BIT_PERIPH_EN   6
`define DCC_BIT_CHG         6
`define DCC_BIT_OUT2        7
`define DCC_BIT_OUT1        6
`define DCC_BIT_IN_SWITCH   3
`define DCC_PORTDIR_MASK    8'h1f
`define DCC_VREF_MASK       8'hef
`define DCC_MODE_INTREF     3'h2
`define DCC_MODE_SHARED     3'h3
`endif

//--- hw/dcc_pkg.sv
// types of the comparator control block
package dcc_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } dcc_bus_t;

    typedef struct packed {
        logic p_first;
        logic n_first;
        logic p_second;
        logic n_second;
    } dcc_route_t;

    typedef enum logic [2:0] {
        DCC_ROUTE_OFF,
        DCC_ROUTE_SPLIT,
        DCC_ROUTE_INTREF,
        DCC_ROUTE_SHARED,
        DCC_ROUTE_SWITCHED
    } dcc_route_mode_t;
endpackage : dcc_pkg

//--- hw/dcc_top.sv
// digital control of a dual analog comparator: mode decode, change detect, interrupt
// Notes on behaviour
// - output low when plus below minus
// - output high when plus above minus
// - mode 010 selects internal voltage reference
// - internal reference feeds both plus inputs
// - external modes: shared or separate references
// - control read ends change; software reads first
// - direction bits 7:5 read zero
`timescale 1ns/1ps
`include "dcc_map.svh"
module dcc_top
    import dcc_pkg::*;
(
    input  wire logic       clk,           // core clock, 125 MHz
    input  wire logic       nrst,          // synchronous reset, active low
    input  wire logic [7:0] addr,          // register address
    input  wire logic [7:0] wdata,         // write data
    input  wire logic       wr,            // write strobe
    input  wire logic       rd,            // read strobe
    output logic      [7:0] rdata,         // read data, cycle after rd
    input  wire logic       cmp_first_raw, // analog comparator 1 result, async
    input  wire logic       cmp_second_raw,// analog comparator 2 result, async
    output dcc_route_t      route,         // analog input switch controls
    output logic            use_intref,    // internal reference selected
    output logic            vref_enable,   // voltage reference enable
    output logic      [3:0] vref_level,    // voltage reference tap
    output logic            out_pin_fourth,// compare result on fourth pin
    output logic            out_pin_fifth, // compare result on fifth pin
    output logic      [4:0] port_dir,      // port direction, 1 = input
    output logic            irq            // level interrupt request
);
    dcc_bus_t bus;
    assign bus = '{addr: addr, wdata: wdata, wr: wr, rd: rd};

    // synchronisers for the analog results
    logic [1:0] s1_r, s2_r, s1_nxt, s2_nxt;
    always_comb begin
        s1_nxt = {cmp_second_raw, cmp_first_raw};
        s2_nxt = s1_r;
    end
    always_ff @(posedge clk) begin
        if (!nrst) begin
            s1_r <= 2'h0;
            s2_r <= 2'h0;
        end else begin
            s1_r <= s1_nxt;
            s2_r <= s2_nxt;
        end
    end

    logic [7:0] intctl_r, pen_r, vref_r, mask_r, ctl_r;
    logic [4:0] dir_r;
    logic       flag_r, stat_r;
    logic [1:0] latch_r, out_r;
    logic [7:0] rdata_r;
    logic [7:0] intctl_nxt, pen_nxt, vref_nxt, mask_nxt, ctl_nxt, rdata_nxt;
    logic [4:0] dir_nxt;
    logic       flag_nxt, stat_nxt;
    logic [1:0] latch_nxt, out_nxt;
    logic       changed;
    logic [2:0] mode;
    logic [7:0] ctl_view;

    assign mode = ctl_r[2:0];
    // live results, held low while comparators are off (mode 111)
    always_comb begin
        out_nxt = (mode == 3'h7) ? 2'h0 : s2_r;
    end
    assign ctl_view = {out_r[1], out_r[0], 2'h0, ctl_r[3:0]};
    assign changed  = (out_r != latch_r);

    always_comb begin
        intctl_nxt = intctl_r;
        pen_nxt    = pen_r;
        vref_nxt   = vref_r;
        mask_nxt   = mask_r;
        ctl_nxt    = ctl_r;
        dir_nxt    = dir_r;
        latch_nxt  = latch_r;
        rdata_nxt  = 8'h00;
        flag_nxt   = flag_r;
        stat_nxt   = stat_r;
        if (bus.wr) begin
            case (bus.addr)
                `DCC_ADDR_INTCTL:   intctl_nxt = bus.wdata;
                `DCC_ADDR_PFLAGS:   flag_nxt   = bus.wdata[`DCC_BIT_CHG];
                `DCC_ADDR_CMPCTL:   ctl_nxt    = {4'h0, bus.wdata[3:0]};
                `DCC_ADDR_PORTDIR:  dir_nxt    = bus.wdata[4:0];
                `DCC_ADDR_PENABLES: pen_nxt    = bus.wdata & 8'h40;
                `DCC_ADDR_VREFCTL:  vref_nxt   = bus.wdata & `DCC_VREF_MASK;
                `DCC_ADDR_CHGMASK:  mask_nxt   = bus.wdata & 8'h40;
                default: ;
            endcase
        end
        if (bus.rd) begin
            case (bus.addr)
                `DCC_ADDR_INTCTL:   rdata_nxt = intctl_r;
                `DCC_ADDR_PFLAGS:   rdata_nxt = {1'b0, flag_r, 6'h00};
                `DCC_ADDR_CMPCTL: begin
                    rdata_nxt = ctl_view;
                    latch_nxt = out_r;
                end
                `DCC_ADDR_PORTDIR:  rdata_nxt = {3'h0, dir_r};
                `DCC_ADDR_PENABLES: rdata_nxt = pen_r;
                `DCC_ADDR_VREFCTL:  rdata_nxt = vref_r;
                `DCC_ADDR_CHGSTAT: begin
                    rdata_nxt = {1'b0, stat_r, 6'h00};
                    stat_nxt  = 1'b0;
                end
                `DCC_ADDR_CHGMASK:  rdata_nxt = mask_r;
                default:            rdata_nxt = 8'h00;
            endcase
        end
        // set beats clear: a change in the clearing cycle stays pending
        if (changed) begin
            flag_nxt = 1'b1;
            stat_nxt = 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!nrst) begin
            intctl_r <= `DCC_RST_INTCTL;
            pen_r    <= `DCC_RST_PENABLES;
            vref_r   <= `DCC_RST_VREFCTL;
            mask_r   <= 8'h00;
            ctl_r    <= `DCC_RST_CMPCTL;
            dir_r    <= 5'h1f;
            latch_r  <= 2'h0;
            out_r    <= 2'h0;
            rdata_r  <= 8'h00;
            flag_r   <= 1'b0;
            stat_r   <= 1'b0;
        end else begin
            intctl_r <= intctl_nxt;
            pen_r    <= pen_nxt;
            vref_r   <= vref_nxt;
            mask_r   <= mask_nxt;
            ctl_r    <= ctl_nxt;
            dir_r    <= dir_nxt;
            latch_r  <= latch_nxt;
            out_r    <= out_nxt;
            rdata_r  <= rdata_nxt;
            flag_r   <= flag_nxt;
            stat_r   <= stat_nxt;
        end
    end
    assign rdata = rdata_r;

    // interrupt: core path plus sticky status under mask
    assign irq = (flag_r & pen_r[`DCC_BIT_CHG] & intctl_r[`DCC_BIT_PERIPH_EN]
                 & intctl_r[`DCC_BIT_GLOBAL_EN])
               | (stat_r & mask_r[`DCC_BIT_CHG]);

    // input routing; p = plus input source, n = minus source
    // p/n: 1 selects the pin normally wired to that comparator input
    dcc_route_mode_t rmode;
    always_comb begin
        case (mode)
            3'h0, 3'h7: rmode = DCC_ROUTE_OFF;
            `DCC_MODE_INTREF: rmode = DCC_ROUTE_INTREF;
            `DCC_MODE_SHARED: rmode = DCC_ROUTE_SHARED;
            3'h6:       rmode = DCC_ROUTE_SWITCHED;
            default:    rmode = DCC_ROUTE_SPLIT;
        endcase
    end
    always_comb begin
        route          = '{p_first: 1'b0, n_first: 1'b0, p_second: 1'b0, n_second: 1'b0};
        use_intref     = 1'b0;
        out_pin_fourth = 1'b0;
        out_pin_fifth  = 1'b0;
        case (rmode)
            DCC_ROUTE_INTREF: begin
                use_intref = 1'b1;
                route      = '{p_first: 1'b0, n_first: 1'b1,
                               p_second: 1'b0, n_second: 1'b1};
            end
            DCC_ROUTE_SHARED: begin
                route          = '{p_first: 1'b1, n_first: 1'b1,
                                   p_second: 1'b1, n_second: 1'b1};
                out_pin_fourth = out_r[0];
                out_pin_fifth  = out_r[1];
            end
            DCC_ROUTE_SPLIT, DCC_ROUTE_SWITCHED: begin
                route = '{p_first: 1'b1, n_first: ~(rmode == DCC_ROUTE_SWITCHED
                          && ctl_r[`DCC_BIT_IN_SWITCH]), p_second: 1'b1, n_second: 1'b1};
            end
            default: ;
        endcase
    end
    assign vref_enable = vref_r[7];
    assign vref_level  = vref_r[3:0];
    assign port_dir    = dir_r;
endmodule : dcc_top

//--- tb/dcc_assertions.sv
// port-level assertions of the comparator control block
`timescale 1ns/1ps
module dcc_checker (
    input wire logic       clk,            // clock
    input wire logic       nrst,           // reset
    input wire logic [7:0] addr,           // address
    input wire logic [7:0] wdata,          // write data
    input wire logic       wr,             // write
    input wire logic       rd,             // read
    input wire logic [7:0] rdata,          // read data
    input wire logic       cmp_first_raw,  // result 1
    input wire logic       cmp_second_raw, // result 2
    input wire logic       use_intref,     // int ref
    input wire logic       out_pin_fourth, // pin 4
    input wire logic       out_pin_fifth,  // pin 5
    input wire logic [4:0] port_dir,       // direction
    input wire logic       irq             // interrupt
);
    logic [2:0] mode_r;
    logic [3:0] quiet_r;
    logic       calm;
    logic       rd_ctl;
    // six quiet edges cover the sync chain and the pin flop
    assign calm   = quiet_r > 4'h5 && mode_r != 3'h7;
    assign rd_ctl = rd && addr == 8'h1f;
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    always_ff @(posedge clk) begin
        if (!nrst || (wr && addr == 8'h1f)) mode_r <= nrst ? wdata[2:0] : 3'h0;
        if (!nrst || wr || $changed(cmp_first_raw) || $changed(cmp_second_raw)) quiet_r <= 4'h0;
        else if (quiet_r != 4'hf) quiet_r <= quiet_r + 4'h1;
    end
    property p_dir; rd && addr == 8'h85 |=> rdata == {3'h0, $past(port_dir)}; endproperty
    a_dir: assert property (p_dir) else $error("direction read wrong");
    property p_gap; rd_ctl |=> rdata[5:4] == 2'h0; endproperty
    a_gap: assert property (p_gap) else $error("control bits 5:4 not zero");
    property p_ref; use_intref == (mode_r == 3'h2); endproperty
    a_ref: assert property (p_ref) else $error("reference select wrong");
    property p_out1; calm && rd_ctl |=> rdata[6] == $past(cmp_first_raw, 2); endproperty
    a_out1: assert property (p_out1) else $error("first result wrong");
    property p_out2; calm && rd_ctl |=> rdata[7] == $past(cmp_second_raw, 2); endproperty
    a_out2: assert property (p_out2) else $error("second result wrong");
    property p_pin4; calm |-> out_pin_fourth == (mode_r == 3'h3 && $past(cmp_first_raw)); endproperty
    a_pin4: assert property (p_pin4) else $error("fourth pin wrong");
    property p_pin5; calm |-> out_pin_fifth == (mode_r == 3'h3 && $past(cmp_second_raw)); endproperty
    a_pin5: assert property (p_pin5) else $error("fifth pin wrong");
    property p_irq; $rose(irq) |-> quiet_r < 4'h8; endproperty
    a_irq: assert property (p_irq) else $error("interrupt without cause");
    c_irq: cover property ($rose(irq));
    c_pin: cover property (mode_r == 3'h3 && out_pin_fourth);
    c_ref: cover property (use_intref);
endmodule : dcc_checker
bind dcc_top dcc_checker dcc_checker_i (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata,
    .cmp_first_raw, .cmp_second_raw, .use_intref, .out_pin_fourth, .out_pin_fifth,
    .port_dir, .irq);

//--- tb/dcc_top_test.sv
// self-checking bench of the comparator control block
`timescale 1ns/1ps
module dcc_top_test;
    logic       clk = 1'b0, nrst = 1'b0, wr = 1'b0, rd = 1'b0, irq;
    logic       cmp_first_raw = 1'b0, cmp_second_raw = 1'b0;
    logic       use_intref, vref_enable, out_pin_fourth, out_pin_fifth;
    logic [7:0] addr = 8'h00, wdata = 8'h00, rdata;
    logic [4:0] port_dir;
    logic [3:0] vref_level;
    int         n_mismatch = 0, n_compared = 0;
    dcc_pkg::dcc_route_t route;
    // address and reset value; 0x42 is unmapped
    logic [15:0] regs [9] = '{16'h0b00, 16'h0c00, 16'h1f00, 16'h851f, 16'h8c00,
                              16'h9f00, 16'h0d00, 16'h8d00, 16'h4200};
    // route per mode {p_first, n_first, p_second, n_second}, switch bit clear
    logic [3:0]  route_exp [8] = '{4'h0, 4'hf, 4'h5, 4'hf, 4'hf, 4'hf, 4'hf, 4'h0};
    dcc_top dcc_top_i (.clk, .nrst, .addr, .wdata, .wr, .rd, .rdata, .cmp_first_raw,
        .cmp_second_raw, .route, .use_intref, .vref_enable, .vref_level, .out_pin_fourth,
        .out_pin_fifth, .port_dir, .irq);
    initial forever #4 clk = ~clk;
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        #1;
    endtask : wr_reg
    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd   <= 1'b0;
        #1;
        check(rdata, exp);
    endtask : rd_chk
    // long enough for the sync chain and the change flag
    task automatic set_raw(input logic a, input logic b);
        @(posedge clk);
        cmp_first_raw  <= a;
        cmp_second_raw <= b;
        repeat (8) @(posedge clk);
        #1;
    endtask : set_raw
    task automatic complete_run;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask : complete_run
    initial begin
        repeat (2000) @(posedge clk);
        n_mismatch++;
        complete_run();
    end
    initial begin
        repeat (4) @(posedge clk);
        nrst <= 1'b1;
        foreach (regs[i]) rd_chk(regs[i][15:8], regs[i][7:0]);
        wr_reg(8'h85, 8'hff);
        rd_chk(8'h85, 8'h1f);
        wr_reg(8'h85, 8'h07);
        check({3'h0, port_dir}, 8'h07);
        wr_reg(8'h9f, 8'hff);
        rd_chk(8'h9f, 8'hef);
        check({3'h0, vref_enable, vref_level}, 8'h1f);
        for (int m = 0; m < 8; m++) begin
            wr_reg(8'h1f, 8'hf0 | 8'(m));
            check({7'h0, use_intref}, {7'h0, m == 2});
            check({4'h0, route}, {4'h0, route_exp[m]});
            rd_chk(8'h1f, 8'(m));
        end
        // switched mode with the input switch bit set swaps the first minus source
        wr_reg(8'h1f, 8'h0e);
        check({4'h0, route}, 8'h0b);
        rd_chk(8'h1f, 8'h0e);
        wr_reg(8'h1f, 8'h03);
        wr_reg(8'h8c, 8'h40);
        wr_reg(8'h0b, 8'hc0);
        rd_chk(8'h1f, 8'h03);
        set_raw(1'b1, 1'b0);
        check({5'h0, out_pin_fifth, out_pin_fourth, irq}, 8'h03);
        rd_chk(8'h0c, 8'h40);
        rd_chk(8'h1f, 8'h43);
        wr_reg(8'h0c, 8'h00);
        set_raw(1'b1, 1'b0);
        check({7'h0, irq}, 8'h00);
        rd_chk(8'h0c, 8'h00);
        set_raw(1'b0, 1'b1);
        check({5'h0, out_pin_fifth, out_pin_fourth, irq}, 8'h05);
        rd_chk(8'h1f, 8'h83);
        wr_reg(8'h0b, 8'h40);
        check({7'h0, irq}, 8'h00);
        wr_reg(8'h8d, 8'h40);
        check({7'h0, irq}, 8'h01);
        rd_chk(8'h0d, 8'h40);
        check({7'h0, irq}, 8'h00);
        rd_chk(8'h0d, 8'h00);
        wr_reg(8'h1f, 8'h02);
        set_raw(1'b1, 1'b1);
        check({5'h0, out_pin_fifth, out_pin_fourth, use_intref}, 8'h01);
        complete_run();
    end
endmodule : dcc_top_test
